/* File: verilog/flash_iap_map.svh */
/*
  Special function register offsets, field positions, command codes and reset
  values of the flash in-application command sequencer.
  Assumes the core's special function register bus presents 8-bit addresses.
*/
`ifndef FLASH_IAP_MAP_SVH
`define FLASH_IAP_MAP_SVH

`define FIAP_KEY_FIRST_ADDR 8'h97
`define FIAP_KEY_SECOND_ADDR 8'hc4
`define FIAP_COMMAND_ADDR 8'hb2
`define FIAP_CONFIG_ADDR 8'hb1
`define FIAP_ADDR_LOW_ADDR 8'hb3
`define FIAP_ADDR_HIGH_ADDR 8'hb4
`define FIAP_DATA_ADDR 8'hb5
`define FIAP_STATE_ADDR 8'hb6

`define FIAP_KEY_FIRST_VAL 8'ha2
`define FIAP_KEY_SECOND_VAL 8'hdf
`define FIAP_ERASE_KEY_VAL 8'h55

`define FIAP_CFG_ENABLE_BIT 6
`define FIAP_ST_BUSY_BIT 7
`define FIAP_ST_REFUSED_BIT 6

`define FIAP_CMD_CHIP_ERASE 7'h01
`define FIAP_CMD_SECURE_PAGE 7'h03
`define FIAP_CMD_DISABLE 7'h05
`define FIAP_CMD_BOOT_CLOCK 7'h08
`define FIAP_CMD_SET_BOOT_VEC 7'h09
`define FIAP_CMD_SECTOR_ERASE 7'h0b
`define FIAP_CMD_BYTE_VERIFY 7'h0c
`define FIAP_CMD_PART0_ERASE 7'h0d
`define FIAP_CMD_BYTE_PROGRAM 7'h0e

`define FIAP_AH_SECURE_BASE 8'h90
`define FIAP_AH_SECURE_LAST 8'h94
`define FIAP_AH_DISABLE_BASE 8'hb0
`define FIAP_AH_DISABLE_LAST 8'hb3
`define FIAP_AH_CLOCK_DOUBLE 8'he0
`define FIAP_AH_BOOT_USER 8'he1
`define FIAP_AH_BOOT_ZERO 8'he2
`define FIAP_AH_SET_BOOT_VEC 8'hf0

`define FIAP_ID_MFR_ADDR 8'h30
`define FIAP_ID_DEV_ADDR 8'h31
`define FIAP_ID_EXT_ADDR 8'h32

`define FIAP_SECTOR_MASK 16'hff80
`define FIAP_PART0_LIMIT 16'h4000
`define FIAP_PAGE_LOCK_RESET 5'h1f
`define FIAP_BOOT_HI_DEFAULT 8'h40

`endif

/* File: verilog/flash_iap_pkg.sv */
/*
  Types shared by the flash in-application command sequencer.
  Assumes the _map header supplies every numeric constant.
*/
`default_nettype none

package flash_iap_pkg;

  typedef enum logic [5:0] {
    FOP_NONE = 6'b000001,
    FOP_CHIP_ERASE = 6'b000010,
    FOP_PART0_ERASE = 6'b000100,
    FOP_SECTOR_ERASE = 6'b001000,
    FOP_BYTE_PROGRAM = 6'b010000,
    FOP_BYTE_VERIFY = 6'b100000
  } flash_op_t;

  typedef enum logic [2:0] {
    KEY_IDLE = 3'b001,
    KEY_FIRST_SEEN = 3'b010,
    KEY_ARMED = 3'b100
  } key_state_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b01,
    SEQ_BUSY = 2'b10
  } seq_state_t;

endpackage : flash_iap_pkg

`default_nettype wire

/* File: verilog/flash_iap_command_sequencer.sv */
/*
  Flash in-application command sequencer: mailbox registers on the core's
  special function register bus, unlock key check, command decode, page
  security, boot and clock settings, and the signature byte read.
  Assumes the flash array runs on core_clk_i, holds flash_done_i high for one
  cycle at the end of each operation and returns read data with it.
*/
`include "flash_iap_map.svh"
`default_nettype none

module flash_iap_command_sequencer #(
  parameter logic [7:0] MFR_ID = 8'h5a,      // arbitrary value
  parameter logic [7:0] DEV_ID = 8'ha5,      // arbitrary value
  parameter logic [7:0] DEV_EXT_ID = 8'h3c,  // arbitrary value
  parameter logic [7:0] BOOT_HI_DEFAULT = `FIAP_BOOT_HI_DEFAULT
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic external_access_pin_b_i,
  output logic cpu_stop_o,
  output logic ext_clock_sel_o,
  output logic timing_osc_en_o,
  output logic flash_req_o,
  output flash_iap_pkg::flash_op_t flash_op_o,
  output logic [15:0] flash_addr_o,
  output logic [7:0] flash_wdata_o,
  input wire logic flash_done_i,
  input wire logic [7:0] flash_rdata_i,
  output logic [4:0] page_unlocked_o,
  output logic six_clock_mode_o,
  output logic boot_from_user_o,
  output logic [15:0] boot_vector_o,
  output logic [3:0] extern_disable_o,
  input wire logic [7:0] id_addr_i,
  output logic [7:0] id_data_o
);

  logic ea_meta_reg;
  logic ea_sync_reg;
  flash_iap_pkg::key_state_t key_reg, key_next;
  flash_iap_pkg::seq_state_t seq_reg, seq_next;
  flash_iap_pkg::flash_op_t op_reg, op_next;
  logic [7:0] config_reg, config_next;
  logic [7:0] command_reg, command_next;
  logic [7:0] flash_addr_low_reg, flash_addr_low_next;
  logic [7:0] flash_addr_high_reg, flash_addr_high_next;
  logic [7:0] flash_data_reg, flash_data_next;
  logic refused_reg, refused_next;
  logic [4:0] lock_reg, lock_next;
  logic clk6_reg, clk6_next;
  logic boot_user_reg, boot_user_next;
  logic [7:0] boot_hi_reg, boot_hi_next;
  logic [3:0] dis_reg, dis_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [7:0] id_reg, id_next;
  logic [15:0] op_addr_reg, op_addr_next;

  logic [15:0] cmd_addr;
  logic [2:0] cmd_page;
  logic cmd_page_open;
  logic [6:0] cmd_code;
  logic ext_exec;

  // pages 0-3 split the primary partition evenly, page 4 is the secondary one
  always_comb
  begin
    cmd_addr = {flash_addr_high_reg, flash_addr_low_reg};
    cmd_code = sfr_wdata_i[6:0];
    ext_exec = ~ea_sync_reg;
    if (cmd_addr < `FIAP_PART0_LIMIT)
    begin
      cmd_page = {1'b0, cmd_addr[13:12]};
    end
    else
    begin
      cmd_page = 3'h4;
    end
    cmd_page_open = lock_reg[cmd_page];
  end

  always_comb
  begin
    key_next = key_reg;
    seq_next = seq_reg;
    op_next = op_reg;
    config_next = config_reg;
    command_next = command_reg;
    flash_addr_low_next = flash_addr_low_reg;
    flash_addr_high_next = flash_addr_high_reg;
    flash_data_next = flash_data_reg;
    refused_next = refused_reg;
    lock_next = lock_reg;
    clk6_next = clk6_reg;
    boot_user_next = boot_user_reg;
    boot_hi_next = boot_hi_reg;
    dis_next = dis_reg;
    op_addr_next = op_addr_reg;
    rdata_next = rdata_reg;
    // any write other than the next expected step disarms the key
    if (sfr_wr_i)
    begin
      key_next = flash_iap_pkg::KEY_IDLE;
      if (sfr_addr_i == `FIAP_KEY_FIRST_ADDR)
      begin
        if (sfr_wdata_i == `FIAP_KEY_FIRST_VAL)
        begin
          key_next = flash_iap_pkg::KEY_FIRST_SEEN;
        end
      end
      else if (sfr_addr_i == `FIAP_KEY_SECOND_ADDR)
      begin
        if (sfr_wdata_i == `FIAP_KEY_SECOND_VAL && key_reg == flash_iap_pkg::KEY_FIRST_SEEN)
        begin
          key_next = flash_iap_pkg::KEY_ARMED;
        end
      end
      else if (sfr_addr_i == `FIAP_CONFIG_ADDR)
      begin
        config_next = sfr_wdata_i;
      end
      else if (sfr_addr_i == `FIAP_ADDR_LOW_ADDR)
      begin
        flash_addr_low_next = sfr_wdata_i;
      end
      else if (sfr_addr_i == `FIAP_ADDR_HIGH_ADDR)
      begin
        flash_addr_high_next = sfr_wdata_i;
      end
      else if (sfr_addr_i == `FIAP_DATA_ADDR)
      begin
        flash_data_next = sfr_wdata_i;
      end
      else if (sfr_addr_i == `FIAP_COMMAND_ADDR)
      begin
        command_next = sfr_wdata_i;
        // the CPU is stopped while busy, so a command never lands mid-operation
        if (key_reg == flash_iap_pkg::KEY_ARMED && config_reg[`FIAP_CFG_ENABLE_BIT]
            && seq_reg == flash_iap_pkg::SEQ_IDLE)
        begin
          refused_next = 1'b0;
          case (cmd_code)
            `FIAP_CMD_CHIP_ERASE:
            begin
              if (flash_data_reg == `FIAP_ERASE_KEY_VAL && ext_exec)
              begin
                op_next = flash_iap_pkg::FOP_CHIP_ERASE;
              end
              else
              begin
                refused_next = 1'b1;
              end
            end
            `FIAP_CMD_PART0_ERASE:
            begin
              if (flash_data_reg == `FIAP_ERASE_KEY_VAL)
              begin
                op_next = flash_iap_pkg::FOP_PART0_ERASE;
              end
              else
              begin
                refused_next = 1'b1;
              end
            end
            `FIAP_CMD_SECTOR_ERASE:
            begin
              op_next = flash_iap_pkg::FOP_SECTOR_ERASE;
              refused_next = ~cmd_page_open;
            end
            `FIAP_CMD_BYTE_PROGRAM:
            begin
              op_next = flash_iap_pkg::FOP_BYTE_PROGRAM;
              refused_next = ~cmd_page_open;
            end
            `FIAP_CMD_BYTE_VERIFY:
            begin
              op_next = flash_iap_pkg::FOP_BYTE_VERIFY;
              refused_next = ~cmd_page_open;
            end
            `FIAP_CMD_SECURE_PAGE:
            begin
              // clearing a bit only ever moves it from unprogrammed to programmed
              if (flash_addr_high_reg >= `FIAP_AH_SECURE_BASE && flash_addr_high_reg <= `FIAP_AH_SECURE_LAST)
              begin
                lock_next[flash_addr_high_reg[2:0]] = 1'b0;
              end
              else
              begin
                refused_next = 1'b1;
              end
            end
            `FIAP_CMD_DISABLE:
            begin
              if (flash_addr_high_reg >= `FIAP_AH_DISABLE_BASE && flash_addr_high_reg <= `FIAP_AH_DISABLE_LAST)
              begin
                dis_next[flash_addr_high_reg[1:0]] = 1'b1;
              end
              else
              begin
                refused_next = 1'b1;
              end
            end
            `FIAP_CMD_BOOT_CLOCK:
            begin
              if (flash_addr_high_reg == `FIAP_AH_CLOCK_DOUBLE)
              begin
                clk6_next = 1'b1;
              end
              else if (flash_addr_high_reg == `FIAP_AH_BOOT_USER)
              begin
                boot_user_next = 1'b1;
              end
              else if (flash_addr_high_reg == `FIAP_AH_BOOT_ZERO)
              begin
                boot_user_next = 1'b0;
              end
              else
              begin
                refused_next = 1'b1;
              end
            end
            `FIAP_CMD_SET_BOOT_VEC:
            begin
              if (flash_addr_high_reg == `FIAP_AH_SET_BOOT_VEC)
              begin
                boot_hi_next = flash_data_reg;
              end
              else
              begin
                refused_next = 1'b1;
              end
            end
            default:
            begin
              refused_next = 1'b1;
            end
          endcase
          if (op_next != flash_iap_pkg::FOP_NONE && !refused_next)
          begin
            seq_next = flash_iap_pkg::SEQ_BUSY;
            if (op_next == flash_iap_pkg::FOP_SECTOR_ERASE)
            begin
              op_addr_next = cmd_addr & `FIAP_SECTOR_MASK;
            end
            else
            begin
              op_addr_next = cmd_addr;
            end
          end
          else
          begin
            op_next = flash_iap_pkg::FOP_NONE;
          end
        end
      end
    end
    case (seq_reg)
      flash_iap_pkg::SEQ_IDLE:
      begin
      end
      flash_iap_pkg::SEQ_BUSY:
      begin
        if (flash_done_i)
        begin
          seq_next = flash_iap_pkg::SEQ_IDLE;
          op_next = flash_iap_pkg::FOP_NONE;
          if (op_reg == flash_iap_pkg::FOP_BYTE_VERIFY)
          begin
            flash_data_next = flash_rdata_i;
          end
          else if (op_reg == flash_iap_pkg::FOP_CHIP_ERASE)
          begin
            lock_next = `FIAP_PAGE_LOCK_RESET;
            dis_next = 4'h0;
            boot_user_next = 1'b0;
            boot_hi_next = BOOT_HI_DEFAULT;
          end
          else if (op_reg == flash_iap_pkg::FOP_PART0_ERASE)
          begin
            lock_next[3:0] = 4'hf;
          end
        end
      end
      default:
      begin
        seq_next = flash_iap_pkg::SEQ_IDLE;
      end
    endcase
    if (sfr_rd_i)
    begin
      if (sfr_addr_i == `FIAP_CONFIG_ADDR)
      begin
        rdata_next = config_reg;
      end
      else if (sfr_addr_i == `FIAP_COMMAND_ADDR)
      begin
        rdata_next = command_reg;
      end
      else if (sfr_addr_i == `FIAP_ADDR_LOW_ADDR)
      begin
        rdata_next = flash_addr_low_reg;
      end
      else if (sfr_addr_i == `FIAP_ADDR_HIGH_ADDR)
      begin
        rdata_next = flash_addr_high_reg;
      end
      else if (sfr_addr_i == `FIAP_DATA_ADDR)
      begin
        rdata_next = flash_data_reg;
      end
      else if (sfr_addr_i == `FIAP_STATE_ADDR)
      begin
        rdata_next = 8'h00;
        rdata_next[`FIAP_ST_BUSY_BIT] = (seq_reg == flash_iap_pkg::SEQ_BUSY);
        rdata_next[`FIAP_ST_REFUSED_BIT] = refused_reg;
      end
      else
      begin
        rdata_next = 8'h00;
      end
    end
  end

  always_comb
  begin
    if (id_addr_i == `FIAP_ID_MFR_ADDR)
    begin
      id_next = MFR_ID;
    end
    else if (id_addr_i == `FIAP_ID_DEV_ADDR)
    begin
      id_next = DEV_ID;
    end
    else if (id_addr_i == `FIAP_ID_EXT_ADDR)
    begin
      id_next = DEV_EXT_ID;
    end
    else
    begin
      id_next = 8'h00;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      ea_meta_reg <= 1'b1;
      ea_sync_reg <= 1'b1;
      key_reg <= flash_iap_pkg::KEY_IDLE;
      seq_reg <= flash_iap_pkg::SEQ_IDLE;
      op_reg <= flash_iap_pkg::FOP_NONE;
      config_reg <= 8'h00;
      command_reg <= 8'h00;
      flash_addr_low_reg <= 8'h00;
      flash_addr_high_reg <= 8'h00;
      flash_data_reg <= 8'h00;
      refused_reg <= 1'b0;
      lock_reg <= `FIAP_PAGE_LOCK_RESET;
      clk6_reg <= 1'b0;
      boot_user_reg <= 1'b0;
      boot_hi_reg <= BOOT_HI_DEFAULT;
      dis_reg <= 4'h0;
      op_addr_reg <= 16'h0000;
      rdata_reg <= 8'h00;
      id_reg <= 8'h00;
    end
    else
    begin
      ea_meta_reg <= external_access_pin_b_i;
      ea_sync_reg <= ea_meta_reg;
      key_reg <= key_next;
      seq_reg <= seq_next;
      op_reg <= op_next;
      config_reg <= config_next;
      command_reg <= command_next;
      flash_addr_low_reg <= flash_addr_low_next;
      flash_addr_high_reg <= flash_addr_high_next;
      flash_data_reg <= flash_data_next;
      refused_reg <= refused_next;
      lock_reg <= lock_next;
      clk6_reg <= clk6_next;
      boot_user_reg <= boot_user_next;
      boot_hi_reg <= boot_hi_next;
      dis_reg <= dis_next;
      op_addr_reg <= op_addr_next;
      rdata_reg <= rdata_next;
      id_reg <= id_next;
    end
  end

  always_comb
  begin
    cpu_stop_o = (seq_reg == flash_iap_pkg::SEQ_BUSY);
    ext_clock_sel_o = (seq_reg == flash_iap_pkg::SEQ_BUSY);
    // verify reads need no pulse timing, so the oscillator stays off for them
    timing_osc_en_o = (seq_reg == flash_iap_pkg::SEQ_BUSY)
                      && (op_reg != flash_iap_pkg::FOP_BYTE_VERIFY);
    flash_req_o = (seq_reg == flash_iap_pkg::SEQ_BUSY);
    flash_op_o = op_reg;
    flash_addr_o = op_addr_reg;
    flash_wdata_o = flash_data_reg;
    sfr_rdata_o = rdata_reg;
    page_unlocked_o = lock_reg;
    six_clock_mode_o = clk6_reg;
    boot_from_user_o = boot_user_reg;
    boot_vector_o = {boot_hi_reg, 8'h00};
    extern_disable_o = dis_reg;
    id_data_o = id_reg;
  end

endmodule : flash_iap_command_sequencer

`default_nettype wire

/* File: verif/flash_iap_checker.sv */
/*
  Port checker for the flash command sequencer.
  Assumes it is bound to the sequencer top and sees its ports only.
*/
`default_nettype none

module flash_iap_checker (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic cpu_stop_o,
  input wire logic ext_clock_sel_o,
  input wire logic timing_osc_en_o,
  input wire logic flash_req_o,
  input wire logic [5:0] flash_op_o,
  input wire logic [15:0] flash_addr_o,
  input wire logic flash_done_i,
  input wire logic [4:0] page_unlocked_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic k1_reg, k2_reg, en_reg;
  logic [7:0] ah_reg, al_reg;
  wire logic [2:0] pg = (ah_reg < 8'h40) ? {1'b0, ah_reg[5:4]} : 3'h4;

  // shadow of the key state and mailbox, rebuilt from the write strobes only
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      k1_reg <= 1'b0;
      k2_reg <= 1'b0;
      en_reg <= 1'b0;
      ah_reg <= 8'h00;
      al_reg <= 8'h00;
    end
    else if (sfr_wr_i)
    begin
      k1_reg <= sfr_addr_i == 8'h97 && sfr_wdata_i == 8'ha2;
      k2_reg <= k1_reg && sfr_addr_i == 8'hc4 && sfr_wdata_i == 8'hdf;
      if (sfr_addr_i == 8'hb1) en_reg <= sfr_wdata_i[6];
      if (sfr_addr_i == 8'hb4) ah_reg <= sfr_wdata_i;
      if (sfr_addr_i == 8'hb3) al_reg <= sfr_wdata_i;
    end
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_cmd_wr;
    sfr_wr_i && sfr_addr_i == 8'hb2 && !flash_req_o;
  endsequence
  sequence s_prog;
    s_cmd_wr ##0 sfr_wdata_i[6:0] == 7'h0e && k2_reg && en_reg;
  endsequence

  property p_off;
    s_cmd_wr ##0 !en_reg |=> !flash_req_o && $stable(page_unlocked_o);
  endproperty
  a_off: assert property (p_off) else $error("command ran while disabled");
  property p_nokey;
    s_cmd_wr ##0 !k2_reg |=> !flash_req_o && $stable(page_unlocked_o);
  endproperty
  a_nokey: assert property (p_nokey) else $error("command ran without keys");
  property p_prog;
    s_prog ##0 page_unlocked_o[pg] |=>
      flash_req_o && flash_op_o == flash_iap_pkg::FOP_BYTE_PROGRAM && flash_addr_o == {ah_reg, al_reg};
  endproperty
  a_prog: assert property (p_prog) else $error("program did not start");
  property p_lock;
    s_prog ##0 !page_unlocked_o[pg] |=> !flash_req_o [*2];
  endproperty
  a_lock: assert property (p_lock) else $error("locked page programmed");
  property p_stop;
    cpu_stop_o == (flash_op_o != flash_iap_pkg::FOP_NONE) && ext_clock_sel_o == cpu_stop_o;
  endproperty
  a_stop: assert property (p_stop) else $error("stop or clock select wrong");
  property p_osc;
    timing_osc_en_o == (flash_op_o inside {flash_iap_pkg::FOP_CHIP_ERASE, flash_iap_pkg::FOP_PART0_ERASE,
                                           flash_iap_pkg::FOP_SECTOR_ERASE, flash_iap_pkg::FOP_BYTE_PROGRAM});
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator enable wrong");
  property p_release;
    flash_req_o && flash_done_i |=> !cpu_stop_o && !timing_osc_en_o;
  endproperty
  a_release: assert property (p_release) else $error("cpu not released");
  property p_sector;
    flash_req_o && flash_op_o == flash_iap_pkg::FOP_SECTOR_ERASE |-> flash_addr_o == {ah_reg, al_reg[7], 7'h00};
  endproperty
  a_sector: assert property (p_sector) else $error("sector address wrong");
endmodule : flash_iap_checker

bind flash_iap_command_sequencer flash_iap_checker chk_i (
  .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
  .sfr_wdata_i(sfr_wdata_i), .cpu_stop_o(cpu_stop_o), .ext_clock_sel_o(ext_clock_sel_o),
  .timing_osc_en_o(timing_osc_en_o), .flash_req_o(flash_req_o), .flash_op_o(flash_op_o),
  .flash_addr_o(flash_addr_o), .flash_done_i(flash_done_i), .page_unlocked_o(page_unlocked_o)
);

`default_nettype wire

/* File: verif/flash_array_model.sv */
/*
  Behavioural flash array behind the sequencer's request port.
  Assumes a level request held until the one-cycle done pulse.
*/
`default_nettype none

module flash_array_model (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic flash_req_i,
  input wire logic [5:0] flash_op_i,
  input wire logic [15:0] flash_addr_i,
  input wire logic [7:0] flash_wdata_i,
  output logic flash_done_o = 1'b0,
  output logic [7:0] flash_rdata_o = 8'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [logic [15:0]];
  logic [7:0] rd;
  logic fire;
  int cnt = 0;
  logic slow = 1'b0;

  // answers alternate fast and slow; read data is scrambled outside the done cycle
  always @(posedge core_clk_i)
  begin
    fire = 1'b0;
    if (!rst_b_i)
      cnt = 0;
    else if (flash_req_i && !flash_done_o)
      cnt = cnt + 1;
    if (cnt > (slow ? 6 : 1))
    begin
      cnt = 0;
      slow = !slow;
      fire = 1'b1;
      rd = mem.exists(flash_addr_i) ? mem[flash_addr_i] : 8'hff;
      // both whole erases wipe everything: partition 1 contents are not modelled
      case (flash_op_i)
        flash_iap_pkg::FOP_BYTE_PROGRAM: mem[flash_addr_i] = flash_wdata_i;
        flash_iap_pkg::FOP_SECTOR_ERASE: for (int i = 0; i < 128; i++) mem.delete(flash_addr_i + 16'(i));
        flash_iap_pkg::FOP_BYTE_VERIFY: rd = rd;
        default: mem.delete();
      endcase
    end
    flash_done_o <= fire;
    flash_rdata_o <= fire ? rd : ~flash_rdata_o;
  end
endmodule : flash_array_model

`default_nettype wire

/* File: verif/flash_iap_command_sequencer_tb.sv */
/*
  Self-checking bench: firmware-style mailbox accesses against the sequencer.
  Assumes the package, the array model and the bound checker are compiled first.
*/
`default_nettype none

module flash_iap_command_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] MFR_ID = 8'h11; // arbitrary value
  localparam logic [7:0] DEV_ID = 8'h22; // arbitrary value
  localparam logic [7:0] EXT_ID = 8'h33; // arbitrary value
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic sfr_wr_i = 1'b0;
  logic sfr_rd_i = 1'b0;
  logic external_access_pin_b_i = 1'b1;
  logic [7:0] sfr_addr_i = 8'h00;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic [7:0] id_addr_i = 8'h00;
  logic cpu_stop_o, ext_clock_sel_o, timing_osc_en_o, flash_req_o, flash_done_i, six_clock_mode_o, boot_from_user_o;
  logic [7:0] sfr_rdata_o, flash_wdata_o, flash_rdata_i, id_data_o;
  logic [15:0] flash_addr_o, boot_vector_o;
  logic [4:0] page_unlocked_o;
  logic [3:0] extern_disable_o;
  flash_iap_pkg::flash_op_t flash_op_o;
  logic [7:0] lk [3] = '{8'h0b, 8'h0c, 8'h0e};
  logic [7:0] ids [4] = '{MFR_ID, DEV_ID, EXT_ID, 8'h00};
  int bad_count = 0;
  int tests_run = 0;

  always #2 core_clk_i = ~core_clk_i;

  flash_iap_command_sequencer #(.MFR_ID(MFR_ID), .DEV_ID(DEV_ID), .DEV_EXT_ID(EXT_ID)) uut (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
    .external_access_pin_b_i(external_access_pin_b_i), .cpu_stop_o(cpu_stop_o),
    .ext_clock_sel_o(ext_clock_sel_o), .timing_osc_en_o(timing_osc_en_o), .flash_req_o(flash_req_o),
    .flash_op_o(flash_op_o), .flash_addr_o(flash_addr_o), .flash_wdata_o(flash_wdata_o),
    .flash_done_i(flash_done_i), .flash_rdata_i(flash_rdata_i), .page_unlocked_o(page_unlocked_o),
    .six_clock_mode_o(six_clock_mode_o), .boot_from_user_o(boot_from_user_o), .boot_vector_o(boot_vector_o),
    .extern_disable_o(extern_disable_o), .id_addr_i(id_addr_i), .id_data_o(id_data_o)
  );

  flash_array_model array_model (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .flash_req_i(flash_req_o), .flash_op_i(flash_op_o),
    .flash_addr_i(flash_addr_o), .flash_wdata_i(flash_wdata_o), .flash_done_o(flash_done_i),
    .flash_rdata_o(flash_rdata_i)
  );

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk1(input logic got, input logic exp);
    chk(16'(got), 16'(exp));
  endtask : chk1

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    sfr_wr_i <= 1'b1;
    @(posedge core_clk_i);
    sfr_wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_i);
    sfr_addr_i <= a;
    sfr_rd_i <= 1'b1;
    @(posedge core_clk_i);
    sfr_rd_i <= 1'b0;
    #1;
    chk(16'(sfr_rdata_o), 16'(exp));
  endtask : rd

  task automatic cmd(input logic [7:0] c);
    wr(8'h97, 8'ha2);
    wr(8'hc4, 8'hdf);
    wr(8'hb2, c);
    #1;
  endtask : cmd

  task automatic wait_idle();
    int n;
    n = 0;
    while (cpu_stop_o !== 1'b0)
    begin
      @(posedge core_clk_i);
      #1;
      n++;
      if (n > 50)
      begin
        bad_count++;
        summarize();
      end
    end
  endtask : wait_idle

  task automatic go(input logic [7:0] c, input flash_iap_pkg::flash_op_t op, input logic [15:0] a, input logic osc);
    cmd(c);
    chk1(cpu_stop_o, 1'b1);
    chk1(ext_clock_sel_o, 1'b1);
    chk1(timing_osc_en_o, osc);
    chk(16'(flash_op_o), 16'(op));
    chk(flash_addr_o, a);
    wait_idle();
    chk1(timing_osc_en_o, 1'b0);
  endtask : go

  initial
  begin
    repeat (3) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    #1;
    chk(16'(page_unlocked_o), 16'h001f);
    chk(boot_vector_o, 16'h4000);
    chk1(six_clock_mode_o, 1'b0);
    rd(8'hb6, 8'h00);
    wr(8'hb4, 8'h12);
    wr(8'hb3, 8'h34);
    wr(8'hb5, 8'ha5);
    cmd(8'h0e);
    chk1(cpu_stop_o, 1'b0);
    wr(8'hb1, 8'h40);
    wr(8'h97, 8'ha2);
    wr(8'hb2, 8'h0e);
    #1;
    chk1(cpu_stop_o, 1'b0);
    wr(8'h97, 8'ha2);
    wr(8'hc4, 8'hdf);
    wr(8'hb5, 8'ha5);
    wr(8'hb2, 8'h0e);
    #1;
    chk1(cpu_stop_o, 1'b0);
    // 1234h still reads ffh and lies outside the code this firmware runs
    go(8'h0e, flash_iap_pkg::FOP_BYTE_PROGRAM, 16'h1234, 1'b1);
    go(8'h0c, flash_iap_pkg::FOP_BYTE_VERIFY, 16'h1234, 1'b0);
    rd(8'hb5, 8'ha5);
    go(8'h0b, flash_iap_pkg::FOP_SECTOR_ERASE, 16'h1200, 1'b1);
    go(8'h0c, flash_iap_pkg::FOP_BYTE_VERIFY, 16'h1234, 1'b0);
    rd(8'hb5, 8'hff);
    wr(8'hb4, 8'h91);
    cmd(8'h03);
    chk(16'(page_unlocked_o), 16'h001d);
    wr(8'hb4, 8'h12);
    for (int i = 0; i < 3; i++)
    begin
      cmd(lk[i]);
      chk1(cpu_stop_o, 1'b0);
      rd(8'hb6, 8'h40);
    end
    wr(8'hb5, 8'h55);
    cmd(8'h0d);
    chk1(cpu_stop_o, 1'b1);
    wait_idle();
    chk(16'(page_unlocked_o), 16'h001f);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'hb4, 8'hb0 + 8'(i));
      cmd(8'h05);
      chk(16'(extern_disable_o), 16'((2 << i) - 1));
    end
    wr(8'hb4, 8'he0);
    cmd(8'h08);
    chk1(six_clock_mode_o, 1'b1);
    wr(8'hb4, 8'he1);
    cmd(8'h08);
    chk1(boot_from_user_o, 1'b1);
    wr(8'hb4, 8'he2);
    cmd(8'h08);
    chk1(boot_from_user_o, 1'b0);
    wr(8'hb4, 8'hf0);
    wr(8'hb5, 8'h20);
    cmd(8'h09);
    chk(boot_vector_o, 16'h2000);
    wr(8'hb4, 8'h94);
    cmd(8'h03);
    chk(16'(page_unlocked_o), 16'h000f);
    wr(8'hb5, 8'h55);
    cmd(8'h01);
    chk1(cpu_stop_o, 1'b0);
    rd(8'hb6, 8'h40);
    @(posedge core_clk_i);
    external_access_pin_b_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    cmd(8'h01);
    chk1(cpu_stop_o, 1'b1);
    wait_idle();
    chk(16'(page_unlocked_o), 16'h001f);
    chk(boot_vector_o, 16'h4000);
    chk(16'(extern_disable_o), 16'h0000);
    rd(8'hb6, 8'h00);
    rd(8'hb2, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge core_clk_i);
      id_addr_i <= 8'h30 + 8'(i);
      @(posedge core_clk_i);
      #1;
      chk(16'(id_data_o), 16'(ids[i]));
    end
    summarize();
  end
endmodule : flash_iap_command_sequencer_tb

`default_nettype wire
